// ===== rtl/cpsd_pkg.sv
package cpsd_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_SYS_HZ = 50_000_000;

    // ==========================================================
    // Frame geometry
    localparam logic [6:0] BITS_32 = 7'h20;
    localparam logic [6:0] BITS_48 = 7'h30;
    localparam logic [6:0] BITS_64 = 7'h40;
    localparam int unsigned WORD_NARROW = 16;
    localparam int unsigned WORD_WIDE = 20;
    localparam logic [5:0] HALF_CNT_MAX = 6'h3f;

    // ==========================================================
    // Master clock ratios, in master clock rising edges per frame
    localparam logic [10:0] RATIO_256 = 11'h100;
    localparam logic [10:0] RATIO_384 = 11'h180;
    localparam logic [10:0] RATIO_512 = 11'h200;
    localparam logic [10:0] MCLK_CNT_MAX = 11'h7ff;
    localparam logic [3:0] SYNC_TOL_BITS = 4'h6;
    localparam logic [1:0] DIV384_LAST = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        FMT_LJ16,
        FMT_LJ20,
        FMT_LJ20_ALT,
        FMT_I2S20
    } cpsd_fmt_e;

    typedef enum logic [1:0] {
        RATIO_NONE,
        RATIO_X256,
        RATIO_X384,
        RATIO_X512
    } cpsd_ratio_e;

    typedef struct packed {
        logic [WORD_WIDE-1:0] left;
        logic [WORD_WIDE-1:0] right;
    } cpsd_pair_s;

    typedef struct packed {
        logic frame_sync;
        logic bit_clock;
        logic data;
    } cpsd_link_s;

endpackage

// ===== rtl/cpsd_clk_ratio.sv
`timescale 1ns/1ns
module cpsd_clk_ratio
    import cpsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic master_clock_input,
    input wire logic fs_rise,
    input wire logic [6:0] frame_bits,
    output cpsd_ratio_e ratio,
    output logic clk256_tick,
    output logic locked
);

    // ==========================================================
    // State
    logic mclk_q;
    logic [10:0] mcnt;
    logic [1:0] div_cnt;
    logic [10:0] next_mcnt;
    logic [1:0] next_div_cnt;
    logic next_clk256_tick;
    logic next_locked;
    cpsd_ratio_e next_ratio;
    logic mclk_rise;
    logic [10:0] ref_cnt;
    logic [10:0] diff;
    logic [17:0] drift_scaled;
    logic [14:0] drift_limit;

    assign mclk_rise = master_clock_input & ~mclk_q;

    // Ratio detect, lock watch and divide to 256x
    always_comb begin
        next_mcnt = mcnt;
        next_div_cnt = div_cnt;
        next_clk256_tick = 1'b0;
        next_locked = locked;
        next_ratio = ratio;
        unique case (ratio)
            RATIO_X384: ref_cnt = RATIO_384;
            RATIO_X512: ref_cnt = RATIO_512;
            default: ref_cnt = RATIO_256;
        endcase
        diff = (mcnt > ref_cnt) ? mcnt - ref_cnt : ref_cnt - mcnt;
        // Drift in bit clocks is diff*bits/ref; compare without a divider
        drift_scaled = 18'(diff) * 18'(frame_bits);
        drift_limit = 15'(SYNC_TOL_BITS) * 15'(ref_cnt);
        if (mclk_rise) begin
            if (mcnt != MCLK_CNT_MAX) begin
                next_mcnt = mcnt + 11'h001;
            end
            // 256x tick: every edge, two of three, or one of two
            unique case (ratio)
                RATIO_X384: begin
                    next_clk256_tick = (div_cnt != DIV384_LAST); // see [RL10]
                    next_div_cnt = (div_cnt == DIV384_LAST) ? 2'h0 : div_cnt + 2'h1;
                end
                RATIO_X512: begin
                    next_clk256_tick = div_cnt[0]; // see [RL10]
                    next_div_cnt = div_cnt + 2'h1;
                end
                RATIO_X256: next_clk256_tick = 1'b1; // see [RL11]
                RATIO_NONE: next_clk256_tick = 1'b0;
            endcase
        end
        if (fs_rise) begin
            next_mcnt = 11'h000;
            next_div_cnt = 2'h0;
            // An exact count names the ratio with no setting needed
            if (mcnt == RATIO_256) begin
                next_ratio = RATIO_X256; // see [RL9]
                next_locked = 1'b1;
            end else if (mcnt == RATIO_384) begin
                next_ratio = RATIO_X384; // see [RL9]
                next_locked = 1'b1;
            end else if (mcnt == RATIO_512) begin
                next_ratio = RATIO_X512; // see [RL9]
                next_locked = 1'b1;
            end else if (ratio == RATIO_NONE || drift_scaled > 18'(drift_limit)) begin
                next_locked = 1'b0; // see [RL13]
            end
        end
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mclk_q <= 1'b0;
            mcnt <= 11'h000;
            div_cnt <= 2'h0;
            clk256_tick <= 1'b0;
            locked <= 1'b0;
            ratio <= RATIO_NONE;
        end else begin
            mclk_q <= master_clock_input;
            mcnt <= next_mcnt;
            div_cnt <= next_div_cnt;
            clk256_tick <= next_clk256_tick;
            locked <= next_locked;
            ratio <= next_ratio;
        end
    end

endmodule // cpsd_clk_ratio

// ===== rtl/cpsd_serial_port.sv
// Function
// [RL1] Works with 32, 48 or 64 bit clocks per frame-sync period.
// [RL2] With 32 bit clocks per frame only the 16-bit format is allowed.
// [RL3] Software variant offers formats zero to three from a register field.
// [RL4] Hardware variant offers formats zero and one from the select pin.
// [RL5] Format zero sends 16-bit words, MSB first, aligned to half start.
// [RL6] Formats one and two send 20-bit words, MSB first, left aligned.
// [RL7] Format three sends 20-bit words, MSB first, I2S framing.
// [RL8] The master clock must be 256, 384 or 512 times sample rate.
// [RL9] The master clock ratio is detected automatically.
// [RL10] Ratios 384x and 512x are divided down to a 256x clock.
// [RL11] The 256x clock drives the filters and modulators.
// [RL12] Capture bits launch after bit clock falling edges or frame-sync edges.
// [RL13] Drift over six bit clocks per frame stops conversion, outputs zero.
// [RL14] Playback data is sampled on bit clock rising edges.
`timescale 1ns/1ns
module cpsd_serial_port
    import cpsd_pkg::*;
#(
    parameter bit HW_CTRL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic frame_sync_input,
    input wire logic serial_bit_clock_input,
    input wire logic serial_data_input,
    input wire logic master_clock_input,
    input wire logic wide_word_select_pin,
    input wire logic [1:0] format_select,
    input cpsd_pair_s capture_sample,
    output logic serial_data_output,
    output logic capture_load,
    output cpsd_pair_s playback_sample,
    output logic playback_valid,
    output logic clk256_tick,
    output cpsd_ratio_e ratio_detect,
    output logic sync_locked,
    output logic frame_bits_ok,
    output logic format_conflict
);

    // ==========================================================
    // Elaboration check
    if (WORD_WIDE < WORD_NARROW) begin : g_bad_width
        $error("wide word must not be narrower than narrow word");
    end

    // ==========================================================
    // Link edge detection
    cpsd_link_s link;
    cpsd_link_s link_q;
    logic bck_rise;
    logic bck_fall;
    logic fs_edge;
    logic fs_rise;

    assign link = '{frame_sync: frame_sync_input, bit_clock: serial_bit_clock_input,
                    data: serial_data_input};
    assign bck_rise = link.bit_clock & ~link_q.bit_clock;
    assign bck_fall = ~link.bit_clock & link_q.bit_clock;
    assign fs_edge = link.frame_sync ^ link_q.frame_sync;
    assign fs_rise = link.frame_sync & ~link_q.frame_sync;

    // ==========================================================
    // Master clock detection and division
    logic [6:0] frame_bits;

    cpsd_clk_ratio u_clk_ratio (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .master_clock_input(master_clock_input),
        .fs_rise(fs_rise),
        .frame_bits(frame_bits),
        .ratio(ratio_detect),
        .clk256_tick(clk256_tick),
        .locked(sync_locked)
    );

    // ==========================================================
    // Frame length and format selection
    logic [6:0] bit_cnt;
    logic [6:0] next_bit_cnt;
    logic [6:0] next_frame_bits;
    logic next_frame_bits_ok;
    logic next_format_conflict;
    cpsd_fmt_e req_fmt;
    cpsd_fmt_e fmt;

    // Requested format comes from the pin or the program field
    always_comb begin
        if (HW_CTRL) begin
            req_fmt = wide_word_select_pin ? FMT_LJ20 : FMT_LJ16; // see [RL4]
        end else begin
            req_fmt = cpsd_fmt_e'(format_select); // see [RL3]
        end
        // A 20-bit word cannot fit a 16-clock half, so fall back to 16 bits
        fmt = (frame_bits == BITS_32) ? FMT_LJ16 : req_fmt; // see [RL2]
    end

    // Count bit clocks per frame-sync period
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_frame_bits = frame_bits;
        next_frame_bits_ok = frame_bits_ok;
        next_format_conflict = (frame_bits == BITS_32) && (req_fmt != FMT_LJ16); // see [RL2]
        if (bck_rise && bit_cnt != 7'h7f) begin
            next_bit_cnt = bit_cnt + 7'h01;
        end
        if (fs_rise) begin
            next_bit_cnt = 7'h00;
            next_frame_bits = bit_cnt;
            next_frame_bits_ok = (bit_cnt == BITS_32) || (bit_cnt == BITS_48)
                || (bit_cnt == BITS_64); // see [RL1]
        end
    end

    // ==========================================================
    // Capture transmit path
    logic [WORD_WIDE-1:0] tx_sh;
    logic [WORD_WIDE-1:0] next_tx_sh;
    logic next_dout;
    logic next_capture_load;
    logic tx_left;
    logic [WORD_WIDE-1:0] tx_word;

    // I2S carries left while sync is low; the justified formats while high
    always_comb begin
        tx_left = (fmt == FMT_I2S20) ? ~link.frame_sync : link.frame_sync;
        tx_word = tx_left ? capture_sample.left : capture_sample.right;
        if (fmt == FMT_LJ16) begin
            tx_word = {tx_word[WORD_WIDE-1 -: WORD_NARROW], {(WORD_WIDE-WORD_NARROW){1'b0}}}; // see [RL5]
        end
        if (!sync_locked) begin
            tx_word = '0; // see [RL13]
        end
    end

    // Shift out MSB first; zeros fill the rest of the half period
    always_comb begin
        next_tx_sh = tx_sh;
        next_dout = serial_data_output;
        next_capture_load = 1'b0;
        if (fs_edge) begin
            next_capture_load = 1'b1;
            if (fmt == FMT_I2S20) begin
                // MSB waits one bit clock after the sync edge
                next_tx_sh = tx_word; // see [RL7]
                next_dout = 1'b0;
            end else begin
                // First bit follows the sync edge directly
                next_dout = tx_word[WORD_WIDE-1]; // see [RL6] [RL12]
                next_tx_sh = {tx_word[WORD_WIDE-2:0], 1'b0};
            end
        end else if (bck_fall) begin
            next_dout = tx_sh[WORD_WIDE-1]; // see [RL12]
            next_tx_sh = {tx_sh[WORD_WIDE-2:0], 1'b0};
        end
    end

    // ==========================================================
    // Playback receive path
    logic [WORD_WIDE-1:0] rx_sh;
    logic [5:0] rx_cnt;
    logic [WORD_WIDE-1:0] next_rx_sh;
    logic [5:0] next_rx_cnt;
    cpsd_pair_s next_playback_sample;
    logic next_playback_valid;
    logic rx_take;
    logic rx_left;
    logic [WORD_WIDE-1:0] rx_word;

    // Format two keeps the first bits, I2S the 20 after the first; format zero and one keep the last
    always_comb begin
        unique case (fmt)
            FMT_LJ20_ALT: rx_take = (rx_cnt < 6'(WORD_WIDE));
            FMT_I2S20: rx_take = (rx_cnt >= 6'h01) && (rx_cnt <= 6'(WORD_WIDE));
            FMT_LJ16, FMT_LJ20: rx_take = 1'b1;
        endcase
        rx_left = (fmt == FMT_I2S20) ? ~link_q.frame_sync : link_q.frame_sync;
        if (fmt == FMT_LJ16) begin
            rx_word = {rx_sh[WORD_NARROW-1:0], {(WORD_WIDE-WORD_NARROW){1'b0}}};
        end else begin
            rx_word = rx_sh;
        end
        if (!sync_locked) begin
            rx_word = '0; // see [RL13]
        end
    end

    // Sample on rising bit clock, hand over at each sync edge
    always_comb begin
        next_rx_sh = rx_sh;
        next_rx_cnt = rx_cnt;
        next_playback_sample = playback_sample;
        next_playback_valid = 1'b0;
        if (fs_edge) begin
            next_rx_cnt = 6'h00;
            next_rx_sh = '0;
            if (rx_left) begin
                next_playback_sample.left = rx_word;
            end else begin
                next_playback_sample.right = rx_word;
                next_playback_valid = 1'b1;
            end
        end else if (bck_rise) begin
            if (rx_take) begin
                next_rx_sh = {rx_sh[WORD_WIDE-2:0], link.data}; // see [RL14]
            end
            if (rx_cnt != HALF_CNT_MAX) begin
                next_rx_cnt = rx_cnt + 6'h01;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            link_q <= '0;
            bit_cnt <= 7'h00;
            frame_bits <= 7'h00;
            frame_bits_ok <= 1'b0;
            format_conflict <= 1'b0;
            tx_sh <= '0;
            serial_data_output <= 1'b0;
            capture_load <= 1'b0;
            rx_sh <= '0;
            rx_cnt <= 6'h00;
            playback_sample <= '0;
            playback_valid <= 1'b0;
        end else begin
            link_q <= link;
            bit_cnt <= next_bit_cnt;
            frame_bits <= next_frame_bits;
            frame_bits_ok <= next_frame_bits_ok;
            format_conflict <= next_format_conflict;
            tx_sh <= next_tx_sh;
            serial_data_output <= next_dout;
            capture_load <= next_capture_load;
            rx_sh <= next_rx_sh;
            rx_cnt <= next_rx_cnt;
            playback_sample <= next_playback_sample;
            playback_valid <= next_playback_valid;
        end
    end

endmodule // cpsd_serial_port

// ===== verification/cpsd_serial_port_props.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker
module cpsd_serial_port_props
    import cpsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic frame_sync_input,
    input wire logic serial_bit_clock_input,
    input wire logic master_clock_input,
    input wire logic serial_data_output,
    input wire logic capture_load,
    input wire logic playback_valid,
    input wire logic clk256_tick,
    input wire cpsd_ratio_e ratio_detect,
    input wire logic sync_locked
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic bck_q, fs_q;
    logic [2:0] ev_age, fs_age, next_ev_age, next_fs_age;
    // Cycles since a launch event; saturates so long quiet spans cannot wrap
    always_comb begin
        next_ev_age = (ev_age == 3'h7) ? ev_age : ev_age + 3'h1;
        next_fs_age = (fs_age == 3'h7) ? fs_age : fs_age + 3'h1;
        if (fs_q != frame_sync_input) begin
            next_ev_age = 3'h0;
            next_fs_age = 3'h0;
        end
        if (bck_q && !serial_bit_clock_input) begin
            next_ev_age = 3'h0;
        end
    end
    // Event history registers
    always_ff @(posedge clk_sys) begin
        bck_q <= serial_bit_clock_input;
        fs_q <= frame_sync_input;
        ev_age <= rst_b ? next_ev_age : 3'h7;
        fs_age <= rst_b ? next_fs_age : 3'h7;
    end
    property p_load_on_sync;
        $changed(frame_sync_input) |-> ##[1:3] capture_load;
    endproperty
    a_load_on_sync: assert property (p_load_on_sync)
        else $error("no capture load after a frame sync edge");
    property p_load_cause;
        capture_load |-> fs_age <= 3'h3 && !$past(capture_load);
    endproperty
    a_load_cause: assert property (p_load_cause)
        else $error("capture load without a frame sync edge");
    property p_valid_pulse;
        playback_valid |=> !playback_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("playback valid longer than one cycle");
    property p_tick_x256;
        $rose(master_clock_input) && ratio_detect == RATIO_X256 |-> ##[1:3] clk256_tick;
    endproperty
    a_tick_x256: assert property (p_tick_x256)
        else $error("missing tick for a master clock rise");
    property p_tick_sparse;
        clk256_tick |=> !clk256_tick;
    endproperty
    a_tick_sparse: assert property (p_tick_sparse)
        else $error("ticks on adjacent cycles");
    property p_unlocked_zero;
        capture_load && !sync_locked && !$past(sync_locked) |-> !serial_data_output;
    endproperty
    a_unlocked_zero: assert property (p_unlocked_zero)
        else $error("capture data while unlocked");
    property p_ratio_judged;
        $changed(ratio_detect) |-> frame_sync_input;
    endproperty
    a_ratio_judged: assert property (p_ratio_judged)
        else $error("ratio changed outside the frame start");
    property p_lock_judged;
        $changed(sync_locked) |-> frame_sync_input;
    endproperty
    a_lock_judged: assert property (p_lock_judged)
        else $error("lock changed outside the frame start");
    property p_dout_launch;
        $changed(serial_data_output) |-> ev_age <= 3'h4;
    endproperty
    a_dout_launch: assert property (p_dout_launch)
        else $error("capture bit moved without a launch edge");
endmodule // cpsd_serial_port_props

bind cpsd_serial_port cpsd_serial_port_props u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .frame_sync_input(frame_sync_input),
    .serial_bit_clock_input(serial_bit_clock_input), .master_clock_input(master_clock_input),
    .serial_data_output(serial_data_output), .capture_load(capture_load),
    .playback_valid(playback_valid), .clk256_tick(clk256_tick),
    .ratio_detect(ratio_detect), .sync_locked(sync_locked)
);

// ===== verification/cpsd_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Audio controller: masters sync, bit clock and master clock
module cpsd_host_model
    import cpsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [11:0] frame_cycles,
    input wire logic [6:0] bit_half,
    input wire logic [2:0] mclk_half,
    input wire logic [63:0] pattern,
    output cpsd_link_s link,
    output logic master_clock_input
);
    logic [11:0] cyc;
    logic [11:0] half_pos;
    // One counter drives all clocks, so sync stays locked to the master clock
    always @(negedge clk_sys) begin
        cyc <= (!run || cyc == frame_cycles - 12'h1) ? 12'h0 : cyc + 12'h1;
    end
    // Clocks stand still while stopped; data moves on bit clock falls only
    always_comb begin
        half_pos = (cyc < frame_cycles / 2) ? cyc : cyc - frame_cycles / 2;
        link.frame_sync = run && cyc < frame_cycles / 2;
        link.bit_clock = run && cyc / bit_half % 2 == 1;
        link.data = run && pattern[63 - half_pos / (bit_half * 2)];
        master_clock_input = run && cyc / mclk_half % 2 == 1;
    end
endmodule // cpsd_host_model

// ===== verification/codec_pcm_serial_port_clock_detect_tb.sv
`timescale 1ns/1ns
module codec_pcm_serial_port_clock_detect_tb;
    import cpsd_pkg::*;
    logic clk_sys = 1'b0, rst_b = 1'b0, run = 1'b0, wide_word_select_pin = 1'b0;
    logic [11:0] frame_cycles = 12'h400;
    logic [6:0] bit_half = 7'h10;
    logic [2:0] mclk_half = 3'h2;
    logic [63:0] pattern = 64'h0, sh = 64'h0, al;
    logic [1:0] format_select = 2'h0;
    logic [15:0] ticks = 16'h0;
    cpsd_pair_s capture_sample = '0, playback_sample;
    cpsd_link_s link;
    cpsd_ratio_e ratio_detect;
    logic master_clock_input, serial_data_output, capture_load, playback_valid;
    logic clk256_tick, sync_locked, frame_bits_ok, format_conflict;
    int bad_count = 0, check_count = 0, seed = 32'hbd7e, nbits = 0, i2s = 0;
    logic [19:0] qc[$];
    logic [39:0] qp[$];
    int t_ratio[6] = '{256, 384, 512, 384, 256, 512};
    int t_bits[6] = '{64, 48, 64, 64, 32, 32};
    int t_fmt[6] = '{0, 1, 2, 3, 1, 3};
    always #10 clk_sys = ~clk_sys;
    cpsd_host_model host (.clk_sys(clk_sys), .run(run), .frame_cycles(frame_cycles),
        .bit_half(bit_half), .mclk_half(mclk_half), .pattern(pattern), .link(link),
        .master_clock_input(master_clock_input));
    cpsd_serial_port uut (.clk_sys(clk_sys), .rst_b(rst_b), .frame_sync_input(link.frame_sync),
        .serial_bit_clock_input(link.bit_clock), .serial_data_input(link.data),
        .master_clock_input(master_clock_input), .wide_word_select_pin(wide_word_select_pin),
        .format_select(format_select), .capture_sample(capture_sample),
        .serial_data_output(serial_data_output), .capture_load(capture_load),
        .playback_sample(playback_sample), .playback_valid(playback_valid),
        .clk256_tick(clk256_tick), .ratio_detect(ratio_detect), .sync_locked(sync_locked),
        .frame_bits_ok(frame_bits_ok), .format_conflict(format_conflict));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Bounded waits; a hang counts as a mismatch and ends the run
    task automatic wait_lock(input logic lvl);
        int n;
        n = 0;
        while (sync_locked !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > 20000) begin
                bad_count++;
                final_report();
            end
        end
    endtask
    task automatic wait_edge(input logic lvl);
        int n;
        n = 0;
        while (link.frame_sync === lvl && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        while (link.frame_sync !== lvl && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 5000) begin
            bad_count++;
            final_report();
        end
    endtask
    // Capture side: bits taken at bit clock rises, word judged at each sync edge
    always @(posedge link.bit_clock) begin
        sh = {sh[62:0], serial_data_output};
        nbits++;
    end
    always @(link.frame_sync) begin
        if (qc.size() > 0) begin
            al = sh << (64 - nbits + i2s);
            check(al[63:44], qc.pop_front());
        end
        sh = 64'h0;
        nbits = 0;
    end
    // Playback side and tick count
    always @(posedge clk_sys) begin
        ticks <= ticks + {15'h0, clk256_tick};
        if (playback_valid === 1'b1 && qp.size() > 0) begin
            check(playback_sample, qp.pop_front());
        end
    end
    task automatic run_case(input int i);
        logic [1:0] eff;
        logic [19:0] w;
        logic [15:0] t0;
        int n;
        run = 1'b0;
        rst_b = 1'b0;
        frame_cycles = 12'(t_ratio[i] * 4);
        bit_half = 7'(t_ratio[i] * 2 / t_bits[i]);
        mclk_half = 3'h2;
        format_select = 2'(t_fmt[i]);
        capture_sample = 40'({$random(seed), $random(seed)});
        pattern = {$random(seed), $random(seed)};
        wide_word_select_pin = 1'($random(seed));
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        run = 1'b1;
        // A 32 bit frame falls back to the 16-bit format
        eff = (t_bits[i] == 32) ? 2'h0 : format_select;
        i2s = (eff == 2'h3);
        n = t_bits[i] / 2;
        wait_lock(1'b1);
        wait_edge(1'b1);
        check(ratio_detect, t_ratio[i] / 128 - 1);
        check(format_conflict, t_bits[i] == 32);
        check(frame_bits_ok, 1);
        for (int k = 0; k < 4; k++) begin
            w = ((k % 2) ^ i2s) ? capture_sample.right : capture_sample.left;
            qc.push_back(eff == 2'h0 ? {w[19:4], 4'h0} : w);
        end
        wait_edge(1'b0);
        w = eff == 2'h0 ? {pattern[64 - n +: 16], 4'h0} : eff == 2'h1 ? pattern[64 - n +: 20] :
            eff == 2'h2 ? pattern[63:44] : pattern[62:43];
        qp.push_back({w, w});
        wait_edge(1'b1);
        t0 = ticks;
        wait_edge(1'b1);
        check(16'(ticks - t0), 16'h100);
        check(qc.size() + qp.size(), 0);
        $display("case %0d done", i);
    endtask
    initial begin
        for (int i = 0; i < 6; i++) begin
            run_case(i);
        end
        // Drifting master clock stops conversion, exact clock relocks
        run_case(0);
        mclk_half = 3'h3;
        wait_lock(1'b0);
        wait_edge(1'b1);
        qc.push_back(20'h0);
        qc.push_back(20'h0);
        wait_edge(1'b1);
        check(ratio_detect, RATIO_X256);
        check(qc.size(), 0);
        mclk_half = 3'h2;
        wait_lock(1'b1);
        check(sync_locked, 1);
        $display("drift case done");
        final_report();
    end
endmodule // codec_pcm_serial_port_clock_detect_tb
